// file: design/mst_pkg.sv
// Shared constants for the motor start sequencer.
// Assumes one system clock; every user of these names imports mst_pkg::*.
package mst_pkg;

	// Sequencer states, Gray coded in declaration order
	typedef enum logic [3:0] {
		ST_POWER_ON = 4'h0,
		ST_IDLE = 4'h1,
		ST_ISD = 4'h3,
		ST_DIR = 4'h2,
		ST_RESYNC = 4'h6,
		ST_REV_EN = 4'h7,
		ST_REV_SPD = 4'h5,
		ST_REV_CL = 4'h4,
		ST_REV_OL = 4'hC,
		ST_COAST_EN = 4'hD,
		ST_COAST = 4'hF,
		ST_BRAKE_EN = 4'hE,
		ST_BRAKE = 4'hA,
		ST_STARTUP = 4'hB,
		ST_OPEN_LOOP = 4'h9,
		ST_CLOSED = 4'h8
	} mst_state_t;

	// Configuration bit values
	localparam logic CFG_ON = 1'h1;
	localparam logic CFG_OFF = 1'h0;
	localparam logic DIR_METHOD_ISD = 1'h0;
	localparam logic DIR_METHOD_REVERSE = 1'h1;
	localparam logic BRAKE_BY_TIME = 1'h0;
	localparam logic BRAKE_BY_CURRENT = 1'h1;
	localparam logic BRAKE_LOW_SIDE = 1'h0;
	localparam logic BRAKE_HIGH_SIDE = 1'h1;
	localparam logic POWER_STANDBY = 1'h0;
	localparam logic POWER_SLEEP = 1'h1;

	// Gate patterns for the three half-bridges
	localparam logic [2:0] GATES_OFF = 3'h0;
	localparam logic [2:0] GATES_ALL = 3'h7;

endpackage

// file: design/mst_sequencer.sv
// Motor start sequencer: decides how to bring the motor up after power-on,
// a non-zero speed command or a direction change request.
// Assumes speed, back-EMF and current figures come from same-clock logic;
// only the speed/wake pin and nrst are asynchronous.
// Notes on behaviour
// - At power-on, load parameters from storage before any drive decision.
// - Idle holds speed reference at zero; sleep or standby per mode and pin.
// - Stay idle while speed reference is zero; leave when it rises.
// - Direction change: method 0 to detect check, 1 to handoff check.
// - Detection enabled goes to stationary check, else to brake check.
// - Back-EMF below either threshold means stationary, go brake check.
// - Spinning: forward goes to resync check, reverse to reverse drive check.
// - Resync enabled goes to resync speed check, disabled to coast check.
// - Fast forward spin enters closed loop seeded; slower enters open loop.
// - Reverse drive enabled goes to reverse speed check, else coast check.
// - Reverse decelerates closed loop above handoff, open loop below.
// - Open loop passes zero, accelerates forward, closes loop when fast.
// - Coast enabled runs coast routine, disabled goes to brake check.
// - Coast switches off all six bridge switches for coast duration.
// - Brake enabled runs brake routine, disabled goes to stationary start-up.
// - Brake by time lasts duration; by current until currents stay low.
// - Current brake still ends when the brake duration expires.
// - Time brake uses selected side; current brake uses low side only.
// - Closed loop runs sensorless field-oriented control on estimated angle.
`timescale 1ns/1ps
module mst_sequencer
	import mst_pkg::*;
#(
	parameter int SW = 16,
	parameter int TW = 16
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic param_load_done,
	input wire logic [SW-1:0] speed_ref,
	input wire logic power_mode_select,
	input wire logic speed_wake_pin,
	input wire logic dir_change_req,
	input wire logic dir_change_method,
	input wire logic initial_detect_enable,
	input wire logic isd_done,
	input wire logic [SW-1:0] isd_bemf,
	input wire logic [SW-1:0] isd_speed,
	input wire logic isd_reverse,
	input wire logic [SW-1:0] stationary_bemf_threshold,
	input wire logic [SW-1:0] tach_output_bemf_threshold,
	input wire logic forward_resync_enable,
	input wire logic [SW-1:0] forward_resync_speed_threshold,
	input wire logic reverse_drive_enable,
	input wire logic [SW-1:0] open_to_closed_handoff_threshold,
	input wire logic [SW-1:0] loop_handoff_threshold,
	input wire logic [SW-1:0] est_speed,
	input wire logic est_reverse,
	input wire logic coast_enable,
	input wire logic [TW-1:0] coast_duration,
	input wire logic brake_enable,
	input wire logic braking_type_select,
	input wire logic braking_side_select,
	input wire logic [TW-1:0] braking_duration,
	input wire logic [SW-1:0] braking_current_threshold,
	input wire logic [TW-1:0] low_current_hold_time,
	input wire logic [SW-1:0] phase_current_a,
	input wire logic [SW-1:0] phase_current_b,
	input wire logic [SW-1:0] phase_current_c,
	input wire logic startup_done,
	output logic param_load_req,
	output logic [SW-1:0] speed_ref_out,
	output logic sleep_req,
	output logic standby_req,
	output logic isd_start,
	output logic bridge_override,
	output logic [2:0] hs_gate_on,
	output logic [2:0] ls_gate_on,
	output logic startup_req,
	output logic open_loop_on,
	output logic closed_loop_on,
	output logic reverse_drive_on,
	output logic seed_from_isd,
	output logic angle_from_estimator,
	output logic [3:0] state_out
);

	logic rst_meta_reg, rst_n;
	logic wake_meta_reg, wake_reg;
	mst_state_t state_reg, state_next;
	logic enter_coast, enter_brake, coast_done, brake_time_done;
	logic low_current, persist_done, brake_over, stationary;
	logic [SW-1:0] speed_ref_out_next;
	logic sleep_next, standby_next, isd_start_next, override_next;
	logic [2:0] hs_next, ls_next;
	logic startup_next, open_next, closed_next, reverse_next;
	logic seed_next, load_req_next;
	// Reset release through two flip-flops
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end
	// Speed/wake pin synchroniser
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wake_meta_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else begin
			wake_meta_reg <= speed_wake_pin;
			wake_reg <= wake_meta_reg;
		end
	end
	// Duration timers, loaded on entry to their routines
	assign enter_coast = (state_next == ST_COAST) && (state_reg != ST_COAST);
	assign enter_brake = (state_next == ST_BRAKE) && (state_reg != ST_BRAKE);
	assign low_current = (phase_current_a < braking_current_threshold) &&
		(phase_current_b < braking_current_threshold) &&
		(phase_current_c < braking_current_threshold);
	mst_timer #(.W(TW)) u_coast_timer (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.load(enter_coast),
		.len(coast_duration),
		.done(coast_done)
	);
	mst_timer #(.W(TW)) u_brake_timer (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.load(enter_brake),
		.len(braking_duration),
		.done(brake_time_done)
	);
	// Persistence restarts whenever any phase current is high
	mst_timer #(.W(TW)) u_persist_timer (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.load(enter_brake || !low_current),
		.len(low_current_hold_time),
		.done(persist_done)
	);
	// Brake end: timeout always applies, current check only when selected
	assign brake_over = brake_time_done ||
		((braking_type_select == BRAKE_BY_CURRENT) && persist_done &&
		low_current);
	// Stationary if back-EMF is below either threshold
	assign stationary = (isd_bemf < stationary_bemf_threshold) ||
		(isd_bemf < tach_output_bemf_threshold);
	// Next state
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_POWER_ON: begin
				if (param_load_done) begin
					state_next = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (speed_ref != '0) begin
					state_next = (initial_detect_enable == CFG_ON) ?
						ST_ISD : ST_BRAKE_EN;
				end
			end
			ST_ISD: begin
				if (isd_done) begin
					state_next = stationary ? ST_BRAKE_EN : ST_DIR;
				end
			end
			ST_DIR: begin
				state_next = isd_reverse ? ST_REV_EN : ST_RESYNC;
			end
			ST_RESYNC: begin
				if (forward_resync_enable == CFG_OFF) begin
					state_next = ST_COAST_EN;
				end else if (isd_speed > forward_resync_speed_threshold) begin
					state_next = ST_CLOSED;
				end else begin
					state_next = ST_OPEN_LOOP;
				end
			end
			ST_REV_EN: begin
				state_next = (reverse_drive_enable == CFG_ON) ?
					ST_REV_SPD : ST_COAST_EN;
			end
			ST_REV_SPD: begin
				state_next = (isd_speed > open_to_closed_handoff_threshold) ?
					ST_REV_CL : ST_REV_OL;
			end
			ST_REV_CL: begin
				if (est_speed < loop_handoff_threshold) begin
					state_next = ST_REV_OL;
				end
			end
			ST_REV_OL: begin
				if (!est_reverse) begin
					state_next = ST_OPEN_LOOP;
				end
			end
			ST_COAST_EN: begin
				state_next = (coast_enable == CFG_ON) ?
					ST_COAST : ST_BRAKE_EN;
			end
			ST_COAST: begin
				if (coast_done) begin
					state_next = ST_BRAKE_EN;
				end
			end
			ST_BRAKE_EN: begin
				state_next = (brake_enable == CFG_ON) ?
					ST_BRAKE : ST_STARTUP;
			end
			ST_BRAKE: begin
				if (brake_over) begin
					state_next = ST_STARTUP;
				end
			end
			ST_STARTUP: begin
				if (startup_done) begin
					state_next = ST_OPEN_LOOP;
				end
			end
			ST_OPEN_LOOP: begin
				if (est_speed > open_to_closed_handoff_threshold) begin
					state_next = ST_CLOSED;
				end
			end
			ST_CLOSED: state_next = ST_CLOSED;
		endcase
		// Stop and direction change apply to a running drive
		if (state_reg == ST_OPEN_LOOP || state_reg == ST_CLOSED) begin
			if (speed_ref == '0) begin
				state_next = ST_IDLE;
			end else if (dir_change_req) begin
				if (dir_change_method == DIR_METHOD_REVERSE) begin
					state_next = ST_REV_SPD;
				end else begin
					state_next = (initial_detect_enable == CFG_ON) ?
						ST_ISD : ST_BRAKE_EN;
				end
			end
		end
	end
	// Output values for the state about to be entered
	always_comb begin
		load_req_next = (state_next == ST_POWER_ON);
		speed_ref_out_next = speed_ref;
		sleep_next = 1'b0;
		standby_next = 1'b0;
		isd_start_next = (state_next == ST_ISD) && (state_reg != ST_ISD);
		override_next = 1'b0;
		hs_next = GATES_OFF;
		ls_next = GATES_OFF;
		startup_next = (state_next == ST_STARTUP);
		open_next = (state_next == ST_OPEN_LOOP) || (state_next == ST_REV_OL);
		closed_next = (state_next == ST_CLOSED) || (state_next == ST_REV_CL);
		reverse_next = (state_next == ST_REV_CL) || (state_next == ST_REV_OL);
		seed_next = (state_reg == ST_RESYNC) && (state_next == ST_CLOSED);
		if (state_next == ST_POWER_ON || state_next == ST_IDLE) begin
			speed_ref_out_next = '0;
		end
		if (state_next == ST_IDLE) begin
			if (power_mode_select == POWER_SLEEP && !wake_reg) begin
				sleep_next = 1'b1;
			end else begin
				standby_next = 1'b1;
			end
		end
		if (state_next == ST_COAST) begin
			override_next = 1'b1;
		end
		if (state_next == ST_BRAKE) begin
			override_next = 1'b1;
			if (braking_type_select == BRAKE_BY_TIME &&
				braking_side_select == BRAKE_HIGH_SIDE) begin
				hs_next = GATES_ALL;
			end else begin
				ls_next = GATES_ALL;
			end
		end
	end
	// State and output registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_POWER_ON;
			param_load_req <= 1'b1;
			speed_ref_out <= '0;
			sleep_req <= 1'b0;
			standby_req <= 1'b0;
			isd_start <= 1'b0;
			bridge_override <= 1'b0;
			hs_gate_on <= GATES_OFF;
			ls_gate_on <= GATES_OFF;
			startup_req <= 1'b0;
			open_loop_on <= 1'b0;
			closed_loop_on <= 1'b0;
			reverse_drive_on <= 1'b0;
			seed_from_isd <= 1'b0;
			angle_from_estimator <= 1'b0;
		end else begin
			state_reg <= state_next;
			param_load_req <= load_req_next;
			speed_ref_out <= speed_ref_out_next;
			sleep_req <= sleep_next;
			standby_req <= standby_next;
			isd_start <= isd_start_next;
			bridge_override <= override_next;
			hs_gate_on <= hs_next;
			ls_gate_on <= ls_next;
			startup_req <= startup_next;
			open_loop_on <= open_next;
			closed_loop_on <= closed_next;
			reverse_drive_on <= reverse_next;
			seed_from_isd <= seed_next;
			angle_from_estimator <= closed_next;
		end
	end
	assign state_out = state_reg;

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence isd_still_s;
		state_reg == ST_ISD && isd_done && stationary;
	endsequence
	sequence brake_timeout_s;
		state_reg == ST_BRAKE && brake_time_done;
	endsequence
	power_load_a: assert property (
		state_reg == ST_POWER_ON && !param_load_done
		|=> state_reg == ST_POWER_ON && param_load_req)
		else $error("left power-on before parameters loaded");
	idle_zero_a: assert property (
		state_reg == ST_IDLE |-> speed_ref_out == '0 &&
		(sleep_req != standby_req))
		else $error("idle without zero reference or power mode");
	idle_hold_a: assert property (
		state_reg == ST_IDLE && speed_ref == '0 |=> state_reg == ST_IDLE)
		else $error("left idle with zero reference");
	isd_still_a: assert property (
		isd_still_s |=> state_reg == ST_BRAKE_EN)
		else $error("stationary motor not sent to brake check");
	resync_cl_a: assert property (
		state_reg == ST_RESYNC && forward_resync_enable == CFG_ON &&
		isd_speed > forward_resync_speed_threshold
		|=> state_reg == ST_CLOSED && seed_from_isd ##1 !seed_from_isd)
		else $error("resync did not enter seeded closed loop");
	coast_off_a: assert property (
		state_reg == ST_COAST |-> bridge_override &&
		hs_gate_on == GATES_OFF && ls_gate_on == GATES_OFF)
		else $error("switch on during coast");
	coast_end_a: assert property (
		state_reg == ST_COAST && coast_done |=> state_reg == ST_BRAKE_EN)
		else $error("coast did not end to brake check");
	brake_side_a: assert property (
		state_reg == ST_BRAKE && braking_type_select == BRAKE_BY_CURRENT
		|-> ls_gate_on == GATES_ALL && hs_gate_on == GATES_OFF)
		else $error("current brake not on low side");
	brake_end_a: assert property (
		brake_timeout_s |=> state_reg == ST_STARTUP && startup_req)
		else $error("brake timeout did not end brake");
	closed_foc_a: assert property (
		state_reg == ST_CLOSED |-> closed_loop_on && angle_from_estimator &&
		!open_loop_on)
		else $error("closed loop without estimated angle");

endmodule

// file: design/mst_timer.sv
// Down-counting duration timer for the sequencer.
// Assumes load and len come from logic on the same clock.
`timescale 1ns/1ps
module mst_timer #(
	parameter int W = 16
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [W-1:0] len,
	output logic done
);

	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;

	// Reload on entry, then count down to zero and hold
	always_comb begin
		cnt_next = cnt_reg;
		if (load) begin
			cnt_next = len;
		end else if (cnt_reg != '0) begin
			cnt_next = cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// Expiry from the count alone, so done never feeds back into load
	assign done = (cnt_reg == '0);

endmodule

// file: sim/mst_stage_model.sv
// Power stage and motor model facing the start sequencer.
// Assumes clk_sys only; the bench presets speed, spin and current.
`timescale 1ns/1ps
module mst_stage_model
	import mst_pkg::*;
(
	input wire logic clk_sys,
	input wire logic bridge_override,
	input wire logic [2:0] hs_gate_on,
	input wire logic [2:0] ls_gate_on,
	input wire logic open_loop_on,
	input wire logic closed_loop_on,
	input wire logic preset,
	input wire logic [15:0] preset_speed,
	input wire logic preset_rev,
	input wire logic [15:0] preset_cur,
	output logic [15:0] cur,
	output logic [15:0] est_speed,
	output logic est_reverse
);
	// Brake bleeds current a step a cycle; open bridge drops it at once
	always @(posedge clk_sys) begin
		if (preset)
			cur <= preset_cur;
		else if (bridge_override && (hs_gate_on | ls_gate_on) == GATES_OFF)
			cur <= 16'h0000;
		else if (bridge_override && cur != 16'h0000)
			cur <= cur - 16'h0001;
	end

	// Driven motor slows through zero, then speeds up forward
	always @(posedge clk_sys) begin
		if (preset) begin
			est_speed <= preset_speed;
			est_reverse <= preset_rev;
		end else if (open_loop_on || closed_loop_on) begin
			if (!est_reverse)
				est_speed <= est_speed + 16'h0001;
			else if (est_speed != 16'h0000)
				est_speed <= est_speed - 16'h0001;
			else
				est_reverse <= 1'b0;
		end
	end
endmodule

// file: sim/tb_mst_sequencer.sv
// Self-checking bench for the start sequencer with a stage model.
// Assumes the sequencer and model sources compile before this file.
`timescale 1ns/1ps
module tb_mst_sequencer
	import mst_pkg::*;
;
	logic clk_sys = 0, nrst = 0, param_load_done = 0, power_mode_select = 0;
	logic speed_wake_pin = 0, dir_change_req = 0, dir_change_method = 0;
	logic initial_detect_enable = 0, isd_done = 1, isd_reverse = 0;
	logic forward_resync_enable = 0, reverse_drive_enable = 0;
	logic coast_enable = 0, brake_enable = 0, braking_type_select = 0;
	logic braking_side_select = 0, startup_done = 0, preset = 0;
	logic preset_rev = 0;
	logic [15:0] speed_ref = 16'h0000, isd_bemf = 16'h0000;
	logic [15:0] isd_speed = 16'h0000, preset_speed = 16'h0000;
	logic [15:0] preset_cur = 16'h0000;
	logic [15:0] bump_b = 16'h0000, bump_c = 16'h0000;
	logic [15:0] stationary_bemf_threshold = 16'h0005;
	logic [15:0] tach_output_bemf_threshold = 16'h0008;
	logic [15:0] forward_resync_speed_threshold = 16'h001E;
	logic [15:0] open_to_closed_handoff_threshold = 16'h0014;
	logic [15:0] loop_handoff_threshold = 16'h000A;
	logic [15:0] coast_duration = 16'h000C, braking_duration = 16'h000F;
	logic [15:0] braking_current_threshold = 16'h000A;
	logic [15:0] low_current_hold_time = 16'h0005;
	logic param_load_req, sleep_req, standby_req, isd_start, bridge_override;
	logic startup_req, open_loop_on, closed_loop_on, reverse_drive_on;
	logic seed_from_isd, angle_from_estimator, est_reverse;
	logic [15:0] speed_ref_out, est_speed, cur;
	logic [2:0] hs_gate_on, ls_gate_on;
	logic [3:0] state_out;
	int err_count = 0, comparisons = 0;

	mst_sequencer dut (.*, .phase_current_a(cur),
		.phase_current_b(cur | bump_b), .phase_current_c(cur | bump_c));
	mst_stage_model model (.*);

	// 20 MHz system clock
	always #25 clk_sys = ~clk_sys;

	// Inputs move 5 ns after each rising edge
	task automatic step();
		@(posedge clk_sys);
		#5;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		$display("Counts: %0d errors, %0d comparisons", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Bounded wait for a state; a miss ends the run
	task automatic wait_st(input mst_state_t s, input int lim);
		for (int i = 0; i < lim && state_out !== s; i++)
			step();
		chk(16'(state_out), 16'(s));
		if (state_out !== s)
			close_out();
	endtask

	// Cycles spent in the present state
	task automatic dwell(input mst_state_t s, output int n);
		n = 0;
		while (state_out === s && n < 400) begin
			step();
			n++;
		end
	endtask

	task automatic cfg(input logic det, rs, rv, co, br);
		initial_detect_enable = det;
		forward_resync_enable = rs;
		reverse_drive_enable = rv;
		coast_enable = co;
		brake_enable = br;
	endtask

	task automatic load(input logic [15:0] spd, input logic rev,
		input logic [15:0] c);
		preset_speed = spd;
		preset_rev = rev;
		preset_cur = c;
		preset = 1'b1;
		step();
		preset = 1'b0;
	endtask

	task automatic go_idle();
		speed_ref = 16'h0000;
		startup_done = 1'b1;
		wait_st(ST_IDLE, 600);
		startup_done = 1'b0;
		isd_reverse = 1'b0;
		chk(speed_ref_out, 16'h0000);
		chk(16'({standby_req, sleep_req}), 16'h0002);
	endtask

	task automatic t_power();
		repeat (10) step();
		chk(16'({param_load_req, state_out}), 16'h0010);
		nrst = 1'b1;
		repeat (5) step();
		chk(16'({param_load_req, state_out}), 16'h0010);
		param_load_done = 1'b1;
		wait_st(ST_IDLE, 4);
		chk(16'({param_load_req, standby_req, sleep_req}), 16'h0002);
		repeat (4) step();
		chk(16'(state_out), 16'(ST_IDLE));
		power_mode_select = 1'b1;
		repeat (4) step();
		chk(16'({standby_req, sleep_req}), 16'h0001);
		speed_wake_pin = 1'b1;
		repeat (4) step();
		chk(16'({standby_req, sleep_req}), 16'h0002);
		power_mode_select = 1'b0;
		speed_wake_pin = 1'b0;
	endtask

	task automatic t_brake(input logic typ, side, input logic [15:0] c, d,
		input logic [2:0] hs, ls, input int lo, hi);
		int n;
		cfg(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
		braking_type_select = typ;
		braking_side_select = side;
		braking_duration = d;
		isd_bemf = 16'h0006;
		load(16'h0000, 1'b0, c);
		speed_ref = 16'h0005;
		wait_st(ST_ISD, 20);
		chk(16'(isd_start), 16'h0001);
		chk(speed_ref_out, 16'h0005);
		wait_st(ST_BRAKE, 20);
		chk(16'({bridge_override, hs_gate_on}), 16'({1'b1, hs}));
		chk(16'(ls_gate_on), 16'(ls));
		dwell(ST_BRAKE, n);
		chk(16'(n >= lo && n <= hi), 16'h0001);
		wait_st(ST_STARTUP, 4);
		chk(16'(startup_req), 16'h0001);
		go_idle();
	endtask

	task automatic t_coast(input logic rev);
		int n;
		cfg(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		isd_bemf = 16'h0032;
		isd_reverse = rev;
		speed_ref = 16'h0005;
		wait_st(ST_COAST, 20);
		chk(16'({bridge_override, hs_gate_on, ls_gate_on}), 16'h0040);
		dwell(ST_COAST, n);
		chk(16'(n >= 12 && n <= 14), 16'h0001);
		wait_st(ST_STARTUP, 6);
		go_idle();
	endtask

	// Forward spin, no resync and no coast: straight to the brake check
	task automatic t_no_coast();
		cfg(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		isd_bemf = 16'h0032;
		speed_ref = 16'h0005;
		wait_st(ST_COAST_EN, 20);
		step();
		chk(16'(state_out), 16'(ST_BRAKE_EN));
		step();
		chk(16'({startup_req, bridge_override}), 16'h0002);
		go_idle();
	endtask

	task automatic t_resync(input logic [15:0] spd, input mst_state_t s);
		cfg(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		isd_bemf = 16'h0032;
		isd_speed = spd;
		load(spd, 1'b0, 16'h0000);
		speed_ref = 16'h0005;
		wait_st(s, 20);
		chk(16'({seed_from_isd, closed_loop_on}), 16'(s == ST_CLOSED ? 3 : 0));
		chk(16'(angle_from_estimator), 16'(s == ST_CLOSED));
		chk(16'(open_loop_on), 16'(s == ST_OPEN_LOOP));
	endtask

	task automatic t_reverse(input logic via);
		cfg(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
		isd_bemf = 16'h0032;
		isd_reverse = 1'b1;
		isd_speed = 16'h0028;
		load(16'h0028, 1'b1, 16'h0000);
		dir_change_method = 1'b1;
		dir_change_req = via;
		speed_ref = 16'h0005;
		step();
		dir_change_req = 1'b0;
		wait_st(ST_REV_CL, 20);
		chk(16'({reverse_drive_on, closed_loop_on, open_loop_on}), 16'h0006);
		wait_st(ST_REV_OL, 60);
		chk(16'({reverse_drive_on, closed_loop_on, open_loop_on}), 16'h0005);
		wait_st(ST_OPEN_LOOP, 60);
		wait_st(ST_CLOSED, 60);
		chk(16'(est_speed > open_to_closed_handoff_threshold), 16'h0001);
	endtask

	initial begin
		t_power();
		cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		speed_ref = 16'h0005;
		wait_st(ST_STARTUP, 10);
		go_idle();
		t_brake(1'b0, 1'b0, 16'h0000, 16'h000F, GATES_OFF, GATES_ALL, 15, 17);
		t_brake(1'b0, 1'b1, 16'h0000, 16'h000F, GATES_ALL, GATES_OFF, 15, 17);
		t_brake(1'b1, 1'b1, 16'h001E, 16'h00C8, GATES_OFF, GATES_ALL, 20, 40);
		t_brake(1'b1, 1'b0, 16'h03E8, 16'h000F, GATES_OFF, GATES_ALL, 15, 17);
		bump_b = 16'h0040;
		t_brake(1'b1, 1'b0, 16'h001E, 16'h0032, GATES_OFF, GATES_ALL, 50, 52);
		bump_b = 16'h0000;
		bump_c = 16'h0040;
		t_brake(1'b1, 1'b0, 16'h001E, 16'h0032, GATES_OFF, GATES_ALL, 50, 52);
		bump_c = 16'h0000;
		t_coast(1'b0);
		t_coast(1'b1);
		t_no_coast();
		t_resync(16'h0019, ST_OPEN_LOOP);
		go_idle();
		t_resync(16'h0028, ST_CLOSED);
		dir_change_method = 1'b0;
		dir_change_req = 1'b1;
		step();
		dir_change_req = 1'b0;
		wait_st(ST_ISD, 6);
		chk(16'(isd_start), 16'h0001);
		wait_st(ST_CLOSED, 20);
		t_reverse(1'b1);
		go_idle();
		t_reverse(1'b0);
		go_idle();
		close_out();
	end
endmodule
